/* File: logic/spog_top.sv */
// Purpose: On/off control, power good and input good for a front-end supply
// Assumes: Analog monitors arrive as synchronous levels and a millivolt word
// Notes: Status pins are open drain; oe low means the pin is pulled low
module spog_top
   import spog_pkg::*;
#(
   // Long counts are parameters so a simulation can shorten them
   parameter int unsigned AC_FAIL_CYC = SPOG_AC_FAIL_CYC,
   parameter int unsigned PG_ON_CYC = SPOG_PG_ON_CYC
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic remote_on_request_pin,
   input wire logic removal_kill_pin,
   input wire logic bus_on_cmd,
   input wire logic bus_off_cmd,
   input wire logic [15:0] main_mv,
   input wire logic rails_in_reg,
   input wire logic fault_ocp,
   input wire logic fault_ovp,
   input wire logic fault_otp,
   input wire logic fault_fan,
   input wire logic share_in_limit,
   input wire logic mains_in_range,
   input wire logic mains_lost_warn,
   input wire logic remote_sense_ok,
   output logic main_enable,
   output logic standby_rail_enable,
   output logic sense_internal,
   output logic [7:0] sense_limit_pct,
   output logic power_good_out,
   output logic power_good_oe,
   output logic input_good_out,
   output logic input_good_oe
);
   logic remote_on_request_n; // Debounced active-low request
   logic removal_kill_input; // Debounced kill, high when floating
   logic on_allowed; // Both control pins in the on state
   logic req_prev_reg; // Request level last cycle, for toggle detect
   logic req_toggle; // Request released: host recovery event
   logic main_ok; // Main rail inside its window
   logic any_fault; // Any protection shutdown
   logic pg_cond; // Level conditions for power good met, apart from the delay and share limit
   logic [SPOG_TMR_W-1:0] pg_cnt_reg; // Power good assertion delay
   logic [SPOG_TMR_W-1:0] ac_cnt_reg; // Bad mains duration
   logic pg_reg; // Power good state
   logic ig_reg; // Input good state
   spog_state_t state_reg; // Output enable sequence
   spog_state_t state_next;

   // Pin conditioning; both pins idle high through their pull-ups
   spog_debounce #(.RESET_VAL(1'b1)) u_deb_on (
      .ref_clk(ref_clk),
      .srst(srst),
      .pin_in(remote_on_request_pin),
      .level_out(remote_on_request_n)
   );
   spog_debounce #(.RESET_VAL(1'b1)) u_deb_kill (
      .ref_clk(ref_clk),
      .srst(srst),
      .pin_in(removal_kill_pin),
      .level_out(removal_kill_input)
   );

   // Window compare helper on the main rail
   function automatic logic in_window(input logic [15:0] mv);
      in_window = (mv >= SPOG_MAIN_MIN_MV) && (mv <= SPOG_MAIN_MAX_MV);
   endfunction

   // Request and kill both low; a floating pin reads high
   assign on_allowed = !remote_on_request_n && !removal_kill_input;
   assign main_ok = in_window(main_mv);
   assign any_fault = fault_ocp | fault_ovp | fault_otp | fault_fan;
   assign req_toggle = remote_on_request_n && !req_prev_reg;

   // Remember request level to spot a release
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         req_prev_reg <= 1'b1;
      end else begin
         req_prev_reg <= remote_on_request_n;
      end
   end

   // Next-state logic for the main output
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SPOG_OFF: begin
            // Bus on command cannot beat the pins; bus off holds us here
            if (on_allowed && !fault_fan && !bus_off_cmd) begin
               state_next = SPOG_ON;
            end
         end
         SPOG_ON: begin
            if (fault_fan) begin
               state_next = SPOG_FAN_LCK;
            end else if (!on_allowed || bus_off_cmd) begin
               state_next = SPOG_OFF;
            end
         end
         SPOG_FAN_LCK: begin
            // Toggle, bus command or mains recycle clears the latch
            if (req_toggle || bus_on_cmd || !mains_in_range) begin
               state_next = SPOG_OFF;
            end
         end
         default: state_next = SPOG_OFF;
      endcase
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_reg <= SPOG_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // Main enable registered; kill forces off at once as it has priority
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         main_enable <= 1'b0;
      end else begin
         main_enable <= (state_next == SPOG_ON) && on_allowed;
      end
   end

   // Standby stays on regardless of the kill input
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         standby_rail_enable <= 1'b0;
      end else begin
         standby_rail_enable <= 1'b1;
      end
   end

   // Fall back to internal sense and clamp the set point
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sense_internal <= 1'b1;
         sense_limit_pct <= SPOG_SENSE_LIM_PCT;
      end else begin
         sense_internal <= !remote_sense_ok;
         sense_limit_pct <= SPOG_SENSE_LIM_PCT;
      end
   end

   // Mains warning gives the early drop ahead of standby loss
   assign pg_cond = main_enable && rails_in_reg && main_ok && !any_fault
      && !mains_lost_warn;

   // Assertion delay; cleared to zero while any paralleled supply is limiting
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pg_cnt_reg <= '0;
      end else if (!pg_cond) begin
         pg_cnt_reg <= '0;
      end else if (share_in_limit) begin
         pg_cnt_reg <= '0;
      end else if (pg_cnt_reg != SPOG_TMR_W'(PG_ON_CYC)) begin
         pg_cnt_reg <= pg_cnt_reg + 1'b1;
      end
   end

   // Power good drops in the cycle after any condition fails
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pg_reg <= 1'b0;
      end else if (!pg_cond) begin
         pg_reg <= 1'b0;
      end else if (pg_cnt_reg == SPOG_TMR_W'(PG_ON_CYC)
         && !share_in_limit) begin
         // A limit arriving on the last count still holds it off
         pg_reg <= 1'b1;
      end
   end

   // Bad mains duration; a short dip does not drop input good
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ac_cnt_reg <= '0;
      end else if (mains_in_range) begin
         ac_cnt_reg <= '0;
      end else if (ac_cnt_reg != SPOG_TMR_W'(AC_FAIL_CYC)) begin
         ac_cnt_reg <= ac_cnt_reg + 1'b1;
      end
   end

   // Input good follows good mains, falls after the bad-mains limit
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ig_reg <= 1'b0;
      end else if (mains_in_range) begin
         ig_reg <= 1'b1;
      end else if (ac_cnt_reg == SPOG_TMR_W'(AC_FAIL_CYC)) begin
         ig_reg <= 1'b0;
      end
   end

   // Open drain: output low always, enable low pulls the pin low
   assign power_good_out = 1'b0;
   assign power_good_oe = pg_reg;
   assign input_good_out = 1'b0;
   assign input_good_oe = ig_reg;

   a_kill_forces_off: assert property (@(posedge ref_clk) disable iff (srst)
      removal_kill_input |=> !main_enable)
      else $error("main on while kill high");
   a_req_high_off: assert property (@(posedge ref_clk) disable iff (srst)
      remote_on_request_n |=> !main_enable)
      else $error("main on while request high");
   a_on_needs_req: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(main_enable) |-> $past(on_allowed))
      else $error("main rose without request");
   a_window_pg_low: assert property (@(posedge ref_clk) disable iff (srst)
      !main_ok |=> !pg_reg)
      else $error("power good high outside window");
   a_fault_pg_low: assert property (@(posedge ref_clk) disable iff (srst)
      any_fault |=> power_good_oe == 1'b0)
      else $error("power good high during fault");
   a_warn_pg_low: assert property (@(posedge ref_clk) disable iff (srst)
      mains_lost_warn |=> !pg_reg)
      else $error("power good high after mains warning");
   a_limit_holds_pg: assert property (@(posedge ref_clk) disable iff (srst)
      share_in_limit && !pg_reg |=> !pg_reg)
      else $error("power good rose during current limit");
   a_pg_needs_reg: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(pg_reg) |-> $past(rails_in_reg) && $past(main_enable))
      else $error("power good rose without regulation");
   a_mains_ig_high: assert property (@(posedge ref_clk) disable iff (srst)
      mains_in_range |=> ig_reg)
      else $error("input good low with good mains");
   a_ig_holds_dip: assert property (@(posedge ref_clk) disable iff (srst)
      ig_reg && !mains_in_range && ac_cnt_reg != SPOG_TMR_W'(AC_FAIL_CYC)
      |=> ig_reg)
      else $error("input good fell before the limit");
   a_fan_latches: assert property (@(posedge ref_clk) disable iff (srst)
      state_reg == SPOG_FAN_LCK && !req_toggle && !bus_on_cmd
      && mains_in_range |=> state_reg == SPOG_FAN_LCK)
      else $error("fan latch left without recovery");
   a_sense_fallback: assert property (@(posedge ref_clk) disable iff (srst)
      !remote_sense_ok |=> sense_internal)
      else $error("no internal sense after loss");
   // Standby is only promised one cycle after reset has been let go
   a_standby_on: assert property (@(posedge ref_clk) disable iff (srst)
      removal_kill_input && !srst |=> standby_rail_enable)
      else $error("standby off with kill high");
endmodule

/* File: common/spog_pkg.sv */
// Purpose: Shared constants for the supply on/off and power-good logic
// Assumes: ref_clk at 20 MHz (50 ns period)
// Notes: Times are kept in their printed unit and cycle counts derive from them, save the debounce, which is given in cycles
package spog_pkg;
   // Clock rate in kHz, so cycles per ms is this figure
   localparam int unsigned SPOG_CLK_KHZ = 20000;
   // Mains out of range longer than this drops input good (ms)
   localparam int unsigned SPOG_AC_FAIL_MS = 20;
   localparam int unsigned SPOG_AC_FAIL_CYC = SPOG_AC_FAIL_MS * SPOG_CLK_KHZ;
   // Power good must fall at least this long before standby is lost (ms)
   localparam int unsigned SPOG_PG_LEAD_MS = 20;
   // Regulation to power good assertion delay, least figure (ms)
   localparam int unsigned SPOG_PG_ON_MS = 100;
   localparam int unsigned SPOG_PG_ON_CYC = SPOG_PG_ON_MS * SPOG_CLK_KHZ;
   // Debounce time on the control pins, in cycles (1 us)
   localparam int unsigned SPOG_DEB_CYC = 20;
   localparam int SPOG_DEB_W = 5;
   // Main rail window in millivolts, and sense limit in percent of nominal
   localparam logic [15:0] SPOG_MAIN_MIN_MV = 16'h2A94; // 10900
   localparam logic [15:0] SPOG_MAIN_MAX_MV = 16'h3390; // 13200
   localparam logic [15:0] SPOG_MAIN_NOM_MV = 16'h2EE0; // 12000
   localparam logic [7:0] SPOG_SENSE_LIM_PCT = 8'h69;   // 105
   // Counter width for the long timers
   localparam int SPOG_TMR_W = 24;
   // Output enable sequence
   typedef enum logic [2:0] {
      SPOG_OFF     = 3'h1,
      SPOG_ON      = 3'h2,
      SPOG_FAN_LCK = 3'h4
   } spog_state_t;
endpackage

/* File: logic/spog_debounce.sv */
// Purpose: Two-stage synchroniser and stability filter for one pin
// Assumes: Pin is asynchronous; result is held until stable for DEB_CYC
// Notes: First flop feeds only the second flop
module spog_debounce
   import spog_pkg::*;
#(
   parameter logic RESET_VAL = 1'b1
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic pin_in,
   output logic level_out
);
   logic sync1_reg; // First synchroniser stage
   logic sync2_reg; // Second stage, safe to use
   logic [SPOG_DEB_W-1:0] cnt_reg; // Stability counter

   // Synchroniser chain; resets to RESET_VAL, the pulled-up level
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sync1_reg <= RESET_VAL;
         sync2_reg <= RESET_VAL;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   // Accept a new level only after it has held steady
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cnt_reg <= '0;
         level_out <= RESET_VAL;
      end else if (sync2_reg == level_out) begin
         cnt_reg <= '0;
      end else if (cnt_reg == SPOG_DEB_W'(SPOG_DEB_CYC - 1)) begin
         cnt_reg <= '0;
         level_out <= sync2_reg;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end
endmodule

/* File: testbench/spog_host_model.sv */
// Purpose: Host side of the supply control pins and status pins
// Assumes: Open collector drivers on both sides, pull-ups as fitted
// Notes: Levels are what the host reads on its pins
module spog_host_model (
   want_on,
   kill_open,
   power_good_out,
   power_good_oe,
   input_good_out,
   input_good_oe,
   remote_on_request_pin,
   removal_kill_pin,
   pg_level,
   ig_level
);
   timeunit 1ns;
   timeprecision 1ps;
   input wire logic want_on; // Host asks for main output
   input wire logic kill_open; // Supply pulled out of its slot
   input wire logic power_good_out;
   input wire logic power_good_oe;
   input wire logic input_good_out;
   input wire logic input_good_oe;
   output logic remote_on_request_pin;
   output logic removal_kill_pin;
   output logic pg_level;
   output logic ig_level;
   // Request pin is pulled low by the host, else the pull-up wins
   assign remote_on_request_pin = want_on ? 1'b0 : 1'b1;
   // Kill pin is grounded in the slot, floats high when removed
   assign removal_kill_pin = kill_open ? 1'b1 : 1'b0;
   // System pull-up raises the status lines once released
   assign pg_level = power_good_oe ? 1'b1 : power_good_out;
   assign ig_level = input_good_oe ? 1'b1 : input_good_out;
endmodule

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench for the on/off and power-good logic
// Assumes: Shortened timers, 20 MHz clock, host model on the pins
// Notes: Each status change pops the oldest expectation of that line
module testbench;
   import spog_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic want_on, kill_open, bus_on_cmd, bus_off_cmd;
   logic [15:0] main_mv;
   logic [3:0] flt; // Over-current, over-voltage, over-temp, fan
   logic rails_in_reg, share_in_limit, mains_in_range;
   logic mains_lost_warn, remote_sense_ok;
   logic remote_on_request_pin, removal_kill_pin, pg_level, ig_level;
   logic main_enable, standby_rail_enable, sense_internal;
   logic [7:0] sense_limit_pct;
   logic power_good_out, power_good_oe, input_good_out, input_good_oe;
   logic [2:0] outs, prev;
   logic exp_q[3][$]; // Expected next value per watched line
   logic [15:0] bad[2] = '{16'h2A93, 16'h3391};
   logic [15:0] good[2] = '{16'h2A94, 16'h3390};
   int errors = 0;
   int samples_checked = 0;
   // Free-running 50 ns clock
   always #25 ref_clk = ~ref_clk;
   spog_top #(.AC_FAIL_CYC(50), .PG_ON_CYC(100)) dut (
      .ref_clk(ref_clk),
      .srst(srst),
      .remote_on_request_pin(remote_on_request_pin),
      .removal_kill_pin(removal_kill_pin),
      .bus_on_cmd(bus_on_cmd),
      .bus_off_cmd(bus_off_cmd),
      .main_mv(main_mv),
      .rails_in_reg(rails_in_reg),
      .fault_ocp(flt[0]),
      .fault_ovp(flt[1]),
      .fault_otp(flt[2]),
      .fault_fan(flt[3]),
      .share_in_limit(share_in_limit),
      .mains_in_range(mains_in_range),
      .mains_lost_warn(mains_lost_warn),
      .remote_sense_ok(remote_sense_ok),
      .main_enable(main_enable),
      .standby_rail_enable(standby_rail_enable),
      .sense_internal(sense_internal),
      .sense_limit_pct(sense_limit_pct),
      .power_good_out(power_good_out),
      .power_good_oe(power_good_oe),
      .input_good_out(input_good_out),
      .input_good_oe(input_good_oe)
   );
   spog_host_model host (
      .want_on(want_on),
      .kill_open(kill_open),
      .power_good_out(power_good_out),
      .power_good_oe(power_good_oe),
      .input_good_out(input_good_out),
      .input_good_oe(input_good_oe),
      .remote_on_request_pin(remote_on_request_pin),
      .removal_kill_pin(removal_kill_pin),
      .pg_level(pg_level),
      .ig_level(ig_level)
   );
   assign outs = {ig_level, pg_level, main_enable};
   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      samples_checked++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic note(int i, logic v);
      exp_q[i].push_back(v);
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Wait, bounded, until every expected change has been seen
   task automatic drain();
      int n;
      n = 0;
      while (exp_q[0].size() + exp_q[1].size() + exp_q[2].size() > 0
             && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 400) chk("pending", 0, 1);
      cyc(3);
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Watcher: any change with no note waiting is itself a mismatch
   always @(negedge ref_clk) begin
      if (!srst) begin
         for (int i = 0; i < 3; i++) begin
            if (outs[i] !== prev[i]) begin
               if (exp_q[i].size() == 0) begin
                  chk($sformatf("spurious %0d", i), prev[i], outs[i]);
               end else begin
                  chk($sformatf("line %0d", i), exp_q[i].pop_front(), outs[i]);
               end
            end
         end
      end
      prev <= outs;
   end
   // Watchdog sized well above the full sequence
   initial begin
      cyc(30000);
      chk("watchdog", 0, 1);
      summarize();
   end
   // Main sequence
   initial begin
      want_on = 0; kill_open = 0; bus_on_cmd = 0; bus_off_cmd = 0;
      main_mv = 16'h2EE0; flt = 4'h0; rails_in_reg = 1;
      share_in_limit = 0; mains_in_range = 0; mains_lost_warn = 0;
      remote_sense_ok = 1;
      void'($urandom(85468));
      cyc(2);
      srst <= 0;
      cyc(3);
      chk("standby", 1, standby_rail_enable);
      chk("sense", 0, sense_internal);
      mains_in_range <= 1;
      note(2, 1);
      drain();
      // Short request glitch must not reach the main output
      want_on <= 1;
      cyc(10);
      want_on <= 0;
      cyc(40);
      want_on <= 1;
      note(0, 1);
      note(1, 1);
      drain();
      // Window edges: one step outside falls, the limit itself holds
      for (int i = 0; i < 2; i++) begin
         main_mv <= bad[i];
         note(1, 0);
         drain();
         main_mv <= good[i];
         note(1, 1);
         drain();
      end
      // Any rail out of regulation drops power good
      rails_in_reg <= 0;
      note(1, 0);
      drain();
      rails_in_reg <= 1;
      note(1, 1);
      drain();
      for (int i = 0; i < 3; i++) begin
         flt[i] <= 1;
         note(1, 0);
         drain();
         flt[i] <= 0;
         note(1, 1);
         drain();
      end
      mains_lost_warn <= 1;
      note(1, 0);
      drain();
      mains_lost_warn <= 0;
      note(1, 1);
      drain();
      // Current limit holds the delay off well past its length
      main_mv <= bad[0];
      note(1, 0);
      drain();
      share_in_limit <= 1;
      main_mv <= 16'h2A94 + 16'($urandom % 2301);
      cyc(150);
      share_in_limit <= 0;
      note(1, 1);
      drain();
      // Fan latch cleared by bus command, request toggle, mains recycle
      for (int k = 0; k < 3; k++) begin
         flt[3] <= 1;
         note(0, 0);
         note(1, 0);
         drain();
         flt[3] <= 0;
         cyc(40);
         if (k == 0) bus_on_cmd <= 1;
         if (k == 1) want_on <= 0;
         if (k == 2) mains_in_range <= 0;
         cyc(1);
         bus_on_cmd <= 0;
         mains_in_range <= 1;
         // Released request must pass the debounce before it counts
         if (k == 1) cyc(40);
         want_on <= 1;
         note(0, 1);
         note(1, 1);
         drain();
      end
      // Bus off holds the main output off for as long as it stands
      bus_off_cmd <= 1;
      note(0, 0);
      note(1, 0);
      drain();
      bus_off_cmd <= 0;
      note(0, 1);
      note(1, 1);
      drain();
      // Kill wins over the request and over a bus on command
      kill_open <= 1;
      note(0, 0);
      note(1, 0);
      drain();
      bus_on_cmd <= 1;
      cyc(1);
      bus_on_cmd <= 0;
      cyc(40);
      chk("standby", 1, standby_rail_enable);
      kill_open <= 0;
      note(0, 1);
      note(1, 1);
      drain();
      remote_sense_ok <= 0;
      cyc(3);
      chk("sense", 1, sense_internal);
      chk("limit", 8'h69, sense_limit_pct);
      want_on <= 0;
      note(0, 0);
      note(1, 0);
      drain();
      // A dip under the limit is ignored, a long loss is not
      mains_in_range <= 0;
      cyc(30);
      mains_in_range <= 1;
      cyc(80);
      mains_in_range <= 0;
      cyc(45);
      chk("early", 1, input_good_oe);
      note(2, 0);
      drain();
      summarize();
   end
endmodule
